// ===== flash_prot_defines.vh
// constants for the flash sector protect and byte program block
// assumes inclusion by bare name from the design files
`ifndef FLASH_PROT_DEFINES_VH
`define FLASH_PROT_DEFINES_VH
// register file addresses (12-bit)
`define ADDR_FLASH_CTRL 12'hff8
`define ADDR_SHARED_SEL 12'hff9
// flash control command values
`define CMD_RESET 8'h00
`define CMD_PROT_SELECT 8'h5e
`define CMD_UNLOCK_1 8'h73
`define CMD_UNLOCK_2 8'h8c
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
// reset values
`define PROT_RESET 8'h00
`define PAGE_RESET 8'h00
`define ERASED_BYTE 8'hff
// timing counts at 50 mhz
`define PROG_TIME_NS 20000
`define ERASE_TIME_NS 40000
`define CLK_PERIOD_NS 20
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES (`ERASE_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== flash_array_mem.v
// flash array model: erase to all ones, program ANDs bits to zero
// assumes one access per cycle from the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defines.vh"
module flash_array_mem #(
   parameter AW = 11,
   parameter PAGE_BITS = 9
) (
   // clock
   input wire sys_clk,
   // operations
   input wire prog_strobe,
   input wire [AW-1:0] prog_addr,
   input wire [7:0] prog_data,
   input wire page_erase_strobe,
   input wire mass_erase_strobe,
   input wire [AW-PAGE_BITS-1:0] erase_page,
   // read port
   input wire [AW-1:0] rd_addr,
   output reg [7:0] rd_data
);
   // storage array
   reg [7:0] mem [0:(1<<AW)-1];
   integer i;
   // erase, program, read
   always @(posedge sys_clk) begin
      if (mass_erase_strobe) begin
         for (i = 0; i < (1<<AW); i = i + 1)
            mem[i] <= `ERASED_BYTE;
      end else if (page_erase_strobe) begin
         for (i = 0; i < (1<<AW); i = i + 1)
            if (i[AW-1:PAGE_BITS] == erase_page)
               mem[i] <= `ERASED_BYTE;
      end else if (prog_strobe) begin
         mem[prog_addr] <= mem[prog_addr] & prog_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // flash_array_mem
`default_nettype wire

// ===== flash_sector_protect.v
// flash controller: sector protect register, erase and byte programming
// assumes cpu register writes are single-cycle strobes on sys_clk
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defines.vh"
module flash_sector_protect #(
   parameter AW = 11,
   parameter PAGE_BITS = 9,
   parameter SECTORS = 8,
   parameter PROG_CYCLES = `PROG_CYCLES,
   parameter ERASE_CYCLES = `ERASE_CYCLES
) (
   // clock and reset
   input wire sys_clk,
   input wire rstn,
   // register file port
   input wire reg_wr,
   input wire reg_rd,
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // cpu program memory store
   input wire program_memory_store,
   input wire program_memory_store_autoinc,
   input wire [AW-1:0] store_addr,
   input wire [7:0] store_data,
   // debug port memory write
   input wire debug_port_wr,
   input wire [AW-1:0] debug_port_addr,
   input wire [7:0] debug_port_data,
   // controller bypass mode
   input wire bypass_mode,
   // flash read
   input wire [AW-1:0] flash_rd_addr,
   output wire [7:0] flash_rd_data,
   // status
   output reg cpu_stall,
   output reg prog_enabled,
   output reg store_refused,
   output reg [AW-1:0] store_addr_next_out
);
   // controller states
   localparam ST_LOCKED = 3'h0;
   localparam ST_UNLK1 = 3'h1;
   localparam ST_UNLOCKED = 3'h2;
   localparam ST_ERASING = 3'h3;
   localparam ST_PROG_OPEN = 3'h4;
   localparam ST_PROGRAMMING = 3'h5;
   // sector index of an address
   function [2:0] sector_of;
      input [AW-1:0] a;
      begin
         sector_of = a[AW-1:AW-3];
      end
   endfunction
   reg [2:0] state_reg; // controller state
   reg [7:0] ctrl_reg; // last control value
   reg [SECTORS-1:0] prot_reg; // sector protect bits
   reg [7:0] page_reg; // page select
   reg mass_reg; // erase scope was mass
   reg [15:0] cnt_reg; // operation timer
   reg prog_strobe_reg; // array program strobe
   reg [AW-1:0] prog_addr_reg; // array program address
   reg [7:0] prog_data_reg; // array program data
   reg page_er_reg; // array page erase strobe
   reg mass_er_reg; // array mass erase strobe
   wire prot_sel; // protect register mapped
   wire ctrl_wr; // control register write
   wire shared_wr; // write at shared address
   wire cpu_req; // cpu store request
   wire any_req; // any program request
   wire [AW-1:0] req_addr; // selected request address
   wire [7:0] req_data; // selected request data
   wire req_in_scope; // address inside erased scope
   wire req_protected; // sector guard for cpu
   wire [SECTORS-1:0] prot_next; // protect next value
   wire [AW-1:0] page_first; // first address of selected page
   wire [AW-1:0] page_last; // last address of selected page
   wire page_protected; // selected page holds a protected sector
   assign page_first = {page_reg[AW-PAGE_BITS-1:0], {PAGE_BITS{1'b0}}};
   assign page_last = {page_reg[AW-PAGE_BITS-1:0], {PAGE_BITS{1'b1}}};
   // a page spans whole sectors, so both of its end sectors are checked
   assign page_protected = prot_reg[sector_of(page_first)] ||
      prot_reg[sector_of(page_last)];
   assign prot_sel = (ctrl_reg == `CMD_PROT_SELECT);
   assign ctrl_wr = reg_wr && (reg_addr == `ADDR_FLASH_CTRL);
   assign shared_wr = reg_wr && (reg_addr == `ADDR_SHARED_SEL);
   assign cpu_req = program_memory_store || program_memory_store_autoinc;
   assign any_req = cpu_req || debug_port_wr;
   assign req_addr = debug_port_wr ? debug_port_addr : store_addr;
   assign req_data = debug_port_wr ? debug_port_data : store_data;
   assign req_in_scope = mass_reg ||
      (req_addr[AW-1:PAGE_BITS] == page_reg[AW-PAGE_BITS-1:0]);
   // debug and bypass writes skip the guard
   assign req_protected = !debug_port_wr && !bypass_mode &&
      prot_reg[sector_of(req_addr)];
   assign prot_next = prot_reg | reg_wdata[SECTORS-1:0];
   // control, protect and page registers
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `CMD_RESET;
         prot_reg <= `PROT_RESET;
         page_reg <= `PAGE_RESET;
      end else begin
         if (ctrl_wr)
            ctrl_reg <= reg_wdata;
         if (shared_wr && prot_sel)
            prot_reg <= prot_next;
         else if (shared_wr && state_reg != ST_ERASING &&
                  state_reg != ST_PROGRAMMING)
            page_reg <= reg_wdata;
      end
   end
   // controller sequencer
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_LOCKED;
         mass_reg <= 1'b0;
         cnt_reg <= 16'h0000;
         prog_strobe_reg <= 1'b0;
         prog_addr_reg <= {AW{1'b0}};
         prog_data_reg <= 8'h00;
         page_er_reg <= 1'b0;
         mass_er_reg <= 1'b0;
         cpu_stall <= 1'b0;
         prog_enabled <= 1'b0;
         store_refused <= 1'b0;
         store_addr_next_out <= {AW{1'b0}};
      end else begin
         prog_strobe_reg <= 1'b0;
         page_er_reg <= 1'b0;
         mass_er_reg <= 1'b0;
         store_refused <= 1'b0;
         case (state_reg)
            ST_LOCKED: begin
               if (ctrl_wr && reg_wdata == `CMD_UNLOCK_1)
                  state_reg <= ST_UNLK1;
               if (any_req)
                  store_refused <= 1'b1;
            end
            ST_UNLK1: begin
               if (ctrl_wr)
                  state_reg <= (reg_wdata == `CMD_UNLOCK_2) ?
                     ST_UNLOCKED : ST_LOCKED;
               if (any_req)
                  store_refused <= 1'b1;
            end
            ST_UNLOCKED, ST_PROG_OPEN: begin
               if (ctrl_wr && reg_wdata == `CMD_MASS_ERASE) begin
                  mass_reg <= 1'b1;
                  if (|prot_reg && !bypass_mode) begin
                     state_reg <= ST_LOCKED;
                     prog_enabled <= 1'b0;
                  end else begin
                     mass_er_reg <= 1'b1;
                     cnt_reg <= ERASE_CYCLES[15:0];
                     state_reg <= ST_ERASING;
                  end
               end else if (ctrl_wr && reg_wdata == `CMD_PAGE_ERASE) begin
                  mass_reg <= 1'b0;
                  if (page_protected && !bypass_mode) begin
                     state_reg <= ST_LOCKED;
                     prog_enabled <= 1'b0;
                  end else begin
                     page_er_reg <= 1'b1;
                     cnt_reg <= ERASE_CYCLES[15:0];
                     state_reg <= ST_ERASING;
                  end
               end else if (ctrl_wr) begin
                  state_reg <= ST_LOCKED;
                  prog_enabled <= 1'b0;
               end else if (any_req) begin
                  if (state_reg == ST_PROG_OPEN && req_in_scope &&
                      !req_protected) begin
                     prog_strobe_reg <= 1'b1;
                     prog_addr_reg <= req_addr;
                     prog_data_reg <= req_data;
                     cnt_reg <= PROG_CYCLES[15:0];
                     cpu_stall <= cpu_req;
                     state_reg <= ST_PROGRAMMING;
                     if (program_memory_store_autoinc)
                        store_addr_next_out <= req_addr + 1'b1;
                     else
                        store_addr_next_out <= req_addr;
                  end else begin
                     store_refused <= 1'b1;
                  end
               end
            end
            ST_ERASING: begin
               if (cnt_reg == 16'h0001) begin
                  state_reg <= ST_PROG_OPEN;
                  prog_enabled <= 1'b1;
               end
               cnt_reg <= cnt_reg - 16'h0001;
            end
            ST_PROGRAMMING: begin
               if (cnt_reg == 16'h0001) begin
                  state_reg <= ST_PROG_OPEN;
                  cpu_stall <= 1'b0;
               end
               cnt_reg <= cnt_reg - 16'h0001;
            end
            default: begin
               state_reg <= ST_LOCKED;
            end
         endcase
      end
   end
   // register read mux
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `ADDR_SHARED_SEL)
            reg_rdata <= prot_sel ? prot_reg : page_reg;
         else if (reg_addr == `ADDR_FLASH_CTRL)
            reg_rdata <= {5'h00, state_reg};
         else
            reg_rdata <= 8'h00;
      end
   end
   // flash array
   flash_array_mem #(
      .AW(AW),
      .PAGE_BITS(PAGE_BITS)
   ) u_array (
      .sys_clk(sys_clk),
      .prog_strobe(prog_strobe_reg),
      .prog_addr(prog_addr_reg),
      .prog_data(prog_data_reg),
      .page_erase_strobe(page_er_reg),
      .mass_erase_strobe(mass_er_reg),
      .erase_page(page_reg[AW-PAGE_BITS-1:0]),
      .rd_addr(flash_rd_addr),
      .rd_data(flash_rd_data)
   );
endmodule // flash_sector_protect
`default_nettype wire

// ===== flash_sector_protect_properties.sv
// checker for flash_sector_protect: protect map, stall and refusal
// assumes only the top module's ports, one clock domain
`timescale 1ns/1ns
`default_nettype none
module flash_sector_protect_properties #(
   parameter AW = 11,
   parameter PROG_CYCLES = 4
) (
   // clock, reset and register port
   input wire sys_clk,
   input wire rstn,
   input wire reg_wr,
   input wire reg_rd,
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // store requests and status
   input wire program_memory_store,
   input wire program_memory_store_autoinc,
   input wire [AW-1:0] store_addr,
   input wire debug_port_wr,
   input wire bypass_mode,
   input wire cpu_stall,
   input wire prog_enabled,
   input wire store_refused,
   input wire [AW-1:0] store_addr_next_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire ctl_wr = reg_wr && reg_addr == 12'hff8; // control write
   wire req = program_memory_store || program_memory_store_autoinc;
   reg sel_reg; // protect register mapped
   reg mass_reg; // last control write was mass erase
   reg [7:0] prot_reg; // expected protect bits
   reg [15:0] cnt_reg; // stall length so far
   // shadows of select, protect bits, erase kind, stall count
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sel_reg <= 1'b0;
         mass_reg <= 1'b0;
         prot_reg <= 8'h00;
         cnt_reg <= 16'h0000;
      end else begin
         if (ctl_wr) begin
            sel_reg <= reg_wdata == 8'h5e;
            mass_reg <= reg_wdata == 8'h63;
         end
         if (reg_wr && reg_addr == 12'hff9 && sel_reg)
            prot_reg <= prot_reg | reg_wdata;
         cnt_reg <= cpu_stall ? cnt_reg + 16'h0001 : 16'h0000;
      end
   end
   chk_prot_readback: assert property (
      reg_rd && reg_addr == 12'hff9 && sel_reg |=> reg_rdata == prot_reg)
      else $error("protect readback differs");
   chk_stall_length: assert property (
      $fell(cpu_stall) |-> $past(cnt_reg) == PROG_CYCLES - 1)
      else $error("stall length wrong");
   chk_stall_cause: assert property (
      $rose(cpu_stall) |-> $past(req && prog_enabled))
      else $error("stall without open store");
   chk_refuse_cause: assert property (
      store_refused |-> $past(req || debug_port_wr))
      else $error("refusal without request");
   // bypass mode lifts the guard, so only plain cpu stores count here
   chk_protect_blocks: assert property (
      req && prog_enabled && !cpu_stall && !bypass_mode &&
      prot_reg[store_addr[AW-1:AW-3]] |=> store_refused && !cpu_stall)
      else $error("protected store taken");
   chk_relock_write: assert property (
      ctl_wr && reg_wdata != 8'h63 && reg_wdata != 8'h95 |=> !prog_enabled)
      else $error("control write left flash open");
   chk_debug_free: assert property (
      debug_port_wr && prog_enabled && mass_reg && !cpu_stall |=>
      !store_refused)
      else $error("debug write refused");
   chk_autoinc_step: assert property (
      program_memory_store_autoinc && prog_enabled && !cpu_stall |=>
      store_refused || store_addr_next_out == $past(store_addr) + 1'b1)
      else $error("autoinc address wrong");
endmodule // flash_sector_protect_properties
bind flash_sector_protect flash_sector_protect_properties #(
   .AW(AW),
   .PROG_CYCLES(PROG_CYCLES)
) chk_i (
   .sys_clk(sys_clk),
   .rstn(rstn),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .program_memory_store(program_memory_store),
   .program_memory_store_autoinc(program_memory_store_autoinc),
   .store_addr(store_addr),
   .debug_port_wr(debug_port_wr),
   .bypass_mode(bypass_mode),
   .cpu_stall(cpu_stall),
   .prog_enabled(prog_enabled),
   .store_refused(store_refused),
   .store_addr_next_out(store_addr_next_out)
);
`default_nettype wire

// ===== flash_shadow.sv
// expected flash array contents for the bench
// assumes the bench calls a task for each accepted operation
`timescale 1ns/1ns
`default_nettype none
module flash_shadow;
   reg [7:0] mem [0:2047]; // one byte per location
   // erased bytes hold all ones
   task erase_page(input [2:0] p);
      integer i;
      for (i = 0; i < 2048; i = i + 1)
         if (p[2] || i[10:9] == p[1:0]) mem[i] = 8'hff;
   endtask
   // programming only clears bits
   task prog(input [10:0] a, input [7:0] d);
      mem[a] = mem[a] & d;
   endtask
endmodule // flash_shadow
`default_nettype wire

// ===== flash_sector_protect_bench.sv
// self-checking bench for flash_sector_protect
// assumes the checker is bound and flash_shadow models the array
`timescale 1ns/1ns
`default_nettype none
module flash_sector_protect_bench;
   localparam PC = 4; // shortened program time
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, pms = 1'b0, pma = 1'b0, dbg = 1'b0;
   logic byp = 1'b0; // bypass programming mode
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, data_b = 8'h00, p, d;
   logic [10:0] addr_b = 11'h000, rd_addr = 11'h000, a;
   wire [7:0] reg_rdata, flash_rd_data;
   wire [10:0] next_addr;
   wire cpu_stall, prog_enabled, store_refused;
   integer errors = 0, n_compared = 0, i;
   logic [31:0] seed = 32'd32; // xorshift state
   always #10 sys_clk = ~sys_clk;
   flash_shadow shadow_i ();
   flash_sector_protect #(
      .PROG_CYCLES(PC),
      .ERASE_CYCLES(8)
   ) flash_sector_protect_i (
      .sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .program_memory_store(pms), .program_memory_store_autoinc(pma),
      .store_addr(addr_b), .store_data(data_b), .debug_port_wr(dbg),
      .debug_port_addr(addr_b), .debug_port_data(data_b),
      .bypass_mode(byp), .flash_rd_addr(rd_addr),
      .flash_rd_data(flash_rd_data), .cpu_stall(cpu_stall),
      .prog_enabled(prog_enabled), .store_refused(store_refused),
      .store_addr_next_out(next_addr));
   // next random byte
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // compare and count
   task chk(input string n, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input [11:0] ad, input [7:0] dt);
      @(posedge sys_clk); reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= dt;
      @(posedge sys_clk); reg_wr <= 1'b0;
   endtask
   task rd(input [11:0] ad, input [7:0] e);
      @(posedge sys_clk); reg_rd <= 1'b1; reg_addr <= ad;
      @(posedge sys_clk); reg_rd <= 1'b0;
      @(posedge sys_clk); #1 chk("reg_rdata", reg_rdata, e);
   endtask
   // kind 0 store, 1 autoinc store, 2 debug write
   task st(input [1:0] k, input [10:0] ad, input [7:0] dt, input r);
      @(posedge sys_clk); addr_b <= ad; data_b <= dt;
      pms <= k == 0; pma <= k == 1; dbg <= k == 2;
      @(posedge sys_clk); pms <= 0; pma <= 0; dbg <= 0;
      #1 chk("store_refused", store_refused, r);
      if (!r) begin
         chk("cpu_stall", cpu_stall, k != 2);
         shadow_i.prog(ad, dt);
         if (k != 2)
            chk("store_addr_next_out", next_addr, 11'(ad + (k == 1)));
      end
      repeat (PC + 2) @(posedge sys_clk);
   endtask
   task fr(input [10:0] ad);
      @(posedge sys_clk); rd_addr <= ad;
      @(posedge sys_clk); #1 chk("flash_rd_data", flash_rd_data, shadow_i.mem[ad]);
   endtask
   // unlock, erase, wait for programming to open
   task open_erase(input [7:0] cmd);
      integer w;
      wr(12'hff8, 8'h73); wr(12'hff8, 8'h8c); wr(12'hff8, cmd);
      for (w = 0; w < 40 && prog_enabled !== 1'b1; w++) @(posedge sys_clk);
      #1 chk("prog_enabled", prog_enabled, 1'b1);
   endtask
   task summarize;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      st(0, 11'h010, 8'h00, 1'b1);
      open_erase(8'h63);
      shadow_i.erase_page(3'h4);
      for (i = 0; i < 6; i++) begin
         a = {1'b0, i[1:0], rnd()};
         fr(a);
         st(i % 3, a, rnd(), 1'b0);
         st(0, a, rnd(), 1'b0);
         fr(a);
      end
      wr(12'hff8, 8'h00); #1 chk("prog_enabled", prog_enabled, 1'b0);
      st(0, 11'h020, 8'h00, 1'b1);
      wr(12'hff8, 8'h5e); rd(12'hff9, 8'h00);
      p = 8'h80 | (rnd() & 8'h70);
      wr(12'hff9, p); rd(12'hff9, p);
      wr(12'hff9, 8'h00); rd(12'hff9, p);
      wr(12'hff8, 8'h00); rd(12'hff9, 8'h00);
      wr(12'hff9, 8'h01); rd(12'hff9, 8'h01);
      open_erase(8'h95);
      shadow_i.erase_page(3'h1);
      d = rnd();
      st(1, 11'h2a0, d, 1'b0);
      st(0, 11'h0a0, d, 1'b1);
      st(0, 11'h7f0, d, 1'b1);
      fr(11'h2a0);
      // mass erase with a protected sector must relock
      wr(12'hff8, 8'h00);
      wr(12'hff8, 8'h73);
      wr(12'hff8, 8'h8c);
      wr(12'hff8, 8'h63);
      repeat (12) @(posedge sys_clk);
      #1 chk("prog_enabled", prog_enabled, 1'b0);
      // bypass erase ignores protection, then cpu guard applies again
      @(posedge sys_clk);
      byp <= 1'b1;
      open_erase(8'h63);
      shadow_i.erase_page(3'h4);
      @(posedge sys_clk);
      byp <= 1'b0;
      st(0, 11'h7f0, d, 1'b1);
      st(2, 11'h7f0, d, 1'b0);
      @(posedge sys_clk);
      byp <= 1'b1;
      st(0, 11'h7e0, ~d, 1'b0);
      @(posedge sys_clk);
      byp <= 1'b0;
      fr(11'h7f0);
      fr(11'h7e0);
      wr(12'hff8, 8'h5e); rd(12'hff9, p);
      wr(12'hff8, 8'h00);
      summarize;
   end
   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      summarize;
   end
endmodule // flash_sector_protect_bench
`default_nettype wire
